// ==== rtl/lbp_pkg.sv ====
// Purpose: constants shared by the LED blink policy block
// Assumes: 200 MHz core clock, AXI4-Lite register access
// Notes: register offsets are word indexes, byte address is four times
package lbp_pkg;
    // ==========================================================
    // clock and timing
    localparam int CLK_MHZ = 200;
    localparam int INTERVAL_MS = 1000; // length of one weighing interval
    localparam int WEIGHT_UNIT_MS = 42; // threshold step
    localparam int INTERVAL_CYC = INTERVAL_MS * 1000 * CLK_MHZ;
    localparam int WEIGHT_UNIT_CYC = WEIGHT_UNIT_MS * 1000 * CLK_MHZ;

    // ==========================================================
    // register indexes and bus address width
    localparam logic [15:0] STATUS_IDX = 16'h40c0;
    localparam logic [15:0] POLICY_IDX = 16'h40c1;
    localparam logic [15:0] BLINK_RATE_IDX = 16'h40c2;
    localparam int ADDR_W = 18;

    // ==========================================================
    // policy register fields
    localparam int THR_LSB = 0;
    localparam int THR_W = 4;
    localparam int ACT_WEIGHT_EN_BIT = 4;
    localparam int COL_FAST_BIT = 5;
    localparam int JABBER_OFF_BIT = 6;
    localparam int LOOPBACK_OFF_BIT = 7;
    localparam int DUTY_INVERT_BIT = 9;
    localparam logic [15:0] POLICY_RESET = 16'h006c;

    // ==========================================================
    // blink rate register fields
    localparam int MODE0_LSB = 12;
    localparam int MODE1_LSB = 8;
    localparam int MODE2_LSB = 4;
    localparam int MODE3_LSB = 0;
    localparam logic [15:0] BLINK_RATE_RESET = 16'hec75;

    // ==========================================================
    // status register fields
    localparam int ST_HEAVY_BIT = 0;
    localparam int ST_MODE_LSB = 1;
    localparam int ST_SUPPRESS_BIT = 3;

    // ==========================================================
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lbp_pkg

// ==== rtl/lbp_led_blink_policy.sv ====
// Purpose: global LED blink policy, traffic weighing and bus registers
// Assumes: activity, collision, loopback and jabber inputs are mclk logic
// Notes: blink rate generators and per-LED enables sit outside
// Operation
// - count rx and tx active time per second; heavy if either beats thr*42ms
// - weight enabled and heavy traffic: activity blinks in mode 0
// - weight disabled (reset): activity always blinks in mode 1
// - inversion bit swaps on and off portions; resets to 0
// - loopback bit stops blinking during internal loopback; resets to 0
// - jabber bit set stops blinking during 10 Mb/s jabber; resets to 1
// - jabber bit clear keeps normal blinking during jabber
// - collision blinks mode 1; select 1 faster, 0 slower; resets to 1
// - global collision blink applies only where the led's bit3 enable is 0
// - mode 0 rate in bits 15:12 (0xe), mode 1 in 11:8 (0xc)
// - mode 2 in 7:4 (0x7), mode 3 in 3:0 (0x5); codes 10-15 even duty
//
// The AXI4-Lite slave port is this design's own decision.
module lbp_led_blink_policy
    import lbp_pkg::*;
#(
    parameter int INTERVAL_CYCLES = INTERVAL_CYC,
    parameter int UNIT_CYCLES = WEIGHT_UNIT_CYC,
    parameter int NUM_LEDS = 3
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // device state
    input wire logic rx_active,
    input wire logic tx_active,
    input wire logic collision,
    input wire logic loopback_mode,
    input wire logic jabber_10m,
    input wire logic [NUM_LEDS-1:0] led_col_blk_en,
    // policy outputs to the led drivers
    output logic [1:0] act_blink_mode,
    output logic [3:0] act_blink_freq,
    output logic [3:0] col_blink_freq,
    output logic col_blink_fast,
    output logic [NUM_LEDS-1:0] led_col_blink,
    output logic blink_suppress,
    output logic duty_invert,
    output logic traffic_heavy,
    output logic [3:0] mode2_freq,
    output logic [3:0] mode3_freq
);
    // ==========================================================
    // registers
    logic [15:0] policy_reg;
    logic [15:0] blink_rate_reg;
    logic [31:0] interval_cnt_reg;
    logic [31:0] rx_cnt_reg;
    logic [31:0] tx_cnt_reg;
    logic heavy_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [1:0] mode_reg;
    logic [3:0] act_freq_reg;
    logic [3:0] col_freq_reg;
    logic [NUM_LEDS-1:0] col_blink_reg;
    logic suppress_reg;

    // decode a byte address into a register select
    function automatic logic [1:0] lbp_decode(input logic [ADDR_W-1:0] a);
        logic [1:0] sel;
        sel = 2'h0;
        if (a == {BLINK_RATE_IDX, 2'h0}) begin
            sel = 2'h1;
        end else if (a == {POLICY_IDX, 2'h0}) begin
            sel = 2'h2;
        end else if (a == {STATUS_IDX, 2'h0}) begin
            sel = 2'h3;
        end
        return sel;
    endfunction : lbp_decode

    // ==========================================================
    // policy decoding
    wire [THR_W-1:0] thr = policy_reg[THR_LSB +: THR_W];
    wire weight_en = policy_reg[ACT_WEIGHT_EN_BIT];
    wire loopback_off = policy_reg[LOOPBACK_OFF_BIT];
    wire jabber_off = policy_reg[JABBER_OFF_BIT];
    wire [31:0] thr_cycles = 32'(thr) * 32'(UNIT_CYCLES);
    wire interval_end = interval_cnt_reg == 32'(INTERVAL_CYCLES - 1);
    wire heavy_next = (rx_cnt_reg > thr_cycles) | (tx_cnt_reg > thr_cycles);
    wire [1:0] mode_next = (weight_en && heavy_reg) ? 2'h0 : 2'h1;
    wire [3:0] mode0_f = blink_rate_reg[MODE0_LSB +: 4];
    wire [3:0] mode1_f = blink_rate_reg[MODE1_LSB +: 4];
    // loopback and jabber gate blinking; outside drivers then show steady
    wire suppress_next = (loopback_off & loopback_mode)
                       | (jabber_off & jabber_10m);
    wire [3:0] act_freq_next = (mode_next == 2'h0) ? mode0_f : mode1_f;
    wire [NUM_LEDS-1:0] col_blink_next =
        {NUM_LEDS{collision}} & ~led_col_blk_en;

    // ==========================================================
    // traffic weighing over one-second intervals
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            interval_cnt_reg <= 32'h0;
            rx_cnt_reg <= 32'h0;
            tx_cnt_reg <= 32'h0;
            heavy_reg <= 1'b0;
        end else if (interval_end) begin
            interval_cnt_reg <= 32'h0;
            rx_cnt_reg <= 32'h0;
            tx_cnt_reg <= 32'h0;
            heavy_reg <= heavy_next;
        end else begin
            interval_cnt_reg <= interval_cnt_reg + 32'h1;
            rx_cnt_reg <= rx_cnt_reg + {31'h0, rx_active};
            tx_cnt_reg <= tx_cnt_reg + {31'h0, tx_active};
        end
    end

    // registered policy outputs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= 2'h1;
            act_freq_reg <= BLINK_RATE_RESET[MODE1_LSB +: 4];
            col_freq_reg <= BLINK_RATE_RESET[MODE1_LSB +: 4];
            col_blink_reg <= '0;
            suppress_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            act_freq_reg <= act_freq_next;
            col_freq_reg <= mode1_f;
            col_blink_reg <= col_blink_next;
            suppress_reg <= suppress_next;
        end
    end

    assign act_blink_mode = mode_reg;
    assign act_blink_freq = act_freq_reg;
    assign col_blink_freq = col_freq_reg;
    assign col_blink_fast = policy_reg[COL_FAST_BIT];
    assign led_col_blink = col_blink_reg;
    assign blink_suppress = suppress_reg;
    assign duty_invert = policy_reg[DUTY_INVERT_BIT];
    assign traffic_heavy = heavy_reg;
    assign mode2_freq = blink_rate_reg[MODE2_LSB +: 4];
    assign mode3_freq = blink_rate_reg[MODE3_LSB +: 4];

    // ==========================================================
    // axi4-lite write path: address and data taken in either order
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_held_reg || aw_take;
    wire w_have = w_held_reg || w_take;
    wire do_write = aw_have && w_have;
    wire [ADDR_W-1:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
    wire [3:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
    wire [1:0] wr_sel = lbp_decode(wr_addr);
    wire [15:0] wr_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire [15:0] policy_next = (policy_reg & ~wr_mask)
                            | (wr_data[15:0] & wr_mask & 16'h02ff);
    wire [15:0] rate_next = (blink_rate_reg & ~wr_mask)
                          | (wr_data[15:0] & wr_mask);

    // write channel holding and response
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            aw_held_reg <= aw_have && !do_write;
            w_held_reg <= w_have && !do_write;
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= (wr_sel == 2'h1 || wr_sel == 2'h2)
                           ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // software registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            policy_reg <= POLICY_RESET;
            blink_rate_reg <= BLINK_RATE_RESET;
        end else if (do_write && wr_sel == 2'h2) begin
            policy_reg <= policy_next;
        end else if (do_write && wr_sel == 2'h1) begin
            blink_rate_reg <= rate_next;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // ==========================================================
    // axi4-lite read path
    assign s_axi_arready = !rvalid_reg;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire [1:0] rd_sel = lbp_decode(s_axi_araddr);
    wire [15:0] status_word = {12'h0, suppress_reg, mode_reg, heavy_reg};
    wire [15:0] rd_word = (rd_sel == 2'h1) ? blink_rate_reg
                        : (rd_sel == 2'h2) ? policy_reg
                        : (rd_sel == 2'h3) ? status_word : 16'h0;

    // read data capture, held until rready
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {16'h0, rd_word};
            rresp_reg <= (rd_sel == 2'h0) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
endmodule : lbp_led_blink_policy

// ==== tb/lbp_led_blink_policy_chk.sv ====
// Purpose: assertions on the ports of the blink policy block
// Assumes: one mclk domain, rst_n async active low
// Notes: bound to every instance of the block
module lbp_chk #(
    parameter int NUM_LEDS = 3
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // device state and policy outputs
    input wire logic collision,
    input wire logic loopback_mode,
    input wire logic jabber_10m,
    input wire logic [NUM_LEDS-1:0] led_col_blk_en,
    input wire logic [NUM_LEDS-1:0] led_col_blink,
    input wire logic blink_suppress,
    input wire logic traffic_heavy,
    input wire logic [1:0] act_blink_mode
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // bus steps
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    wr_answer_a: assert property (wr_both |=> s_axi_bvalid)
        else $error("no write response after taken write");
    rd_answer_a: assert property (ar_taken |=> s_axi_rvalid)
        else $error("no read data after taken address");
    b_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    r_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    // ==========================================================
    // policy outputs
    light_mode_a: assert property (
        !traffic_heavy |=> act_blink_mode == 2'h1)
        else $error("light traffic without mode 1");
    col_follow_a: assert property ($past(rst_n) |->
        led_col_blink == $past({NUM_LEDS{collision}} & ~led_col_blk_en))
        else $error("collision blink does not follow enables");
    quiet_state_a: assert property (
        !loopback_mode && !jabber_10m |=> !blink_suppress)
        else $error("suppression without cause");
    heavy_hold_a: assert property (
        $rose(traffic_heavy) |=> traffic_heavy [*8])
        else $error("heavy flag dropped inside interval");
endmodule : lbp_chk

bind lbp_led_blink_policy lbp_chk #(.NUM_LEDS(NUM_LEDS)) u_chk (.*);

// ==== tb/lbp_led_blink_policy_tb_top.sv ====
// Purpose: directed bench for the blink policy block
// Assumes: short interval of 100 cycles, weight unit of 4 cycles
// Notes: bus tasks start and end on a rising edge
module lbp_led_blink_policy_tb_top
    import lbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // stimulus and observed signals
    logic mclk = 1'b0, rst_n = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic rx_active = 1'b0, tx_active = 1'b0, collision = 1'b0;
    logic loopback_mode = 1'b0, jabber_10m = 1'b0;
    logic [2:0] led_col_blk_en = '0, led_col_blink;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, col_blink_fast, blink_suppress, duty_invert;
    logic traffic_heavy;
    logic [1:0] s_axi_bresp, s_axi_rresp, act_blink_mode;
    logic [3:0] act_blink_freq, col_blink_freq, mode2_freq, mode3_freq;
    int bad_count = 0, checks_done = 0;
    localparam logic [ADDR_W-1:0] A_ST = {STATUS_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] A_POL = {POLICY_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] A_BR = {BLINK_RATE_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] A_BAD = 18'h10400;

    lbp_led_blink_policy #(.INTERVAL_CYCLES(100), .UNIT_CYCLES(4)) DUT (.*);

    always #2.5 mclk = ~mclk;

    // ==========================================================
    // compare, bus and closing tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d,
                      input logic [1:0] er);
        logic ad, wd, ta, tw, tb;
        logic [1:0] r;
        ad = 0;
        wd = 0;
        tb = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd)) begin
            @(negedge mclk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            @(posedge mclk);
            if (ta) begin
                s_axi_awvalid <= 1'b0;
                ad = 1;
            end
            if (tw) begin
                s_axi_wvalid <= 1'b0;
                wd = 1;
            end
        end
        while (!tb) begin
            @(negedge mclk);
            tb = (s_axi_bvalid === 1'b1);
            r = s_axi_bresp;
            @(posedge mclk);
        end
        s_axi_bready <= 1'b0;
        chk(r, er);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        ta = 0;
        tr = 0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!ta) begin
            @(negedge mclk);
            ta = (s_axi_arready === 1'b1);
            @(posedge mclk);
        end
        s_axi_arvalid <= 1'b0;
        while (!tr) begin
            @(negedge mclk);
            tr = (s_axi_rvalid === 1'b1);
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge mclk);
        end
        s_axi_rready <= 1'b0;
        chk(d, ed);
        chk(r, er);
    endtask : rd

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        rd(A_POL, 32'h006c, RESP_OKAY);
        rd(A_BR, 32'hec75, RESP_OKAY);
        rd(A_ST, 32'h0002, RESP_OKAY);
        @(negedge mclk);
        chk(act_blink_mode, 2'h1);
        chk(act_blink_freq, 4'hc);
        chk(col_blink_fast, 1'b1);
        chk(duty_invert, 1'b0);
        chk({mode2_freq, mode3_freq}, 8'h75);
        rd(A_BAD, 32'h0, RESP_SLVERR);
        wr(A_BAD, 16'hffff, RESP_SLVERR);
        wr(A_ST, 16'hffff, RESP_SLVERR);
        wr(A_BR, 16'h1234, RESP_OKAY);
        rd(A_BR, 32'h1234, RESP_OKAY);
        @(negedge mclk);
        chk({col_blink_freq, act_blink_freq}, 8'h22);
        chk({mode2_freq, mode3_freq}, 8'h34);
        wr(A_POL, 16'h02d2, RESP_OKAY);
        @(posedge mclk);
        loopback_mode <= 1'b1;
        collision <= 1'b1;
        led_col_blk_en <= 3'b010;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk(duty_invert, 1'b1);
        chk(col_blink_fast, 1'b0);
        chk(blink_suppress, 1'b1);
        chk(led_col_blink, 3'b101);
        @(posedge mclk);
        loopback_mode <= 1'b0;
        jabber_10m <= 1'b1;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk(blink_suppress, 1'b1);
        wr(A_POL, 16'h0292, RESP_OKAY);
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk(blink_suppress, 1'b0);
        for (int i = 0; i < 3; i++) begin
            if (i == 2)
                wr(A_POL, 16'h0282, RESP_OKAY);
            @(posedge mclk);
            jabber_10m <= 1'b0;
            rx_active <= (i != 1);
            tx_active <= (i == 1);
            repeat (250) @(posedge mclk);
            @(negedge mclk);
            chk(traffic_heavy, 1'b1);
            chk(act_blink_mode, 32'(i == 2));
            chk(act_blink_freq, (i == 2) ? 4'h2 : 4'h1);
            if (i == 0)
                rd(A_ST, 32'h0001, RESP_OKAY);
            @(posedge mclk);
            rx_active <= 1'b0;
            tx_active <= 1'b0;
            repeat (250) @(posedge mclk);
            @(negedge mclk);
            chk(traffic_heavy, 1'b0);
            chk(act_blink_mode, 2'h1);
        end
        close_out();
    end

    // watchdog against a hung handshake
    initial begin
        #100us;
        bad_count++;
        close_out();
    end
endmodule : lbp_led_blink_policy_tb_top
